// ==== verilog/tpc_params.svh ====
// Constants for the teleprinter character controller.
`ifndef TPC_PARAMS_SVH
`define TPC_PARAMS_SVH
`define TPC_CLK_NS      25
`define TPC_UNIT_NS     9090909
`define TPC_UNIT_CYC    (`TPC_UNIT_NS / `TPC_CLK_NS)
`define TPC_FRAME_LAST  4'ha
`define TPC_INFO_BITS   4'h8
`define TPC_LINE_LEN    7'h48
`define TPC_BELL_POS    7'h47
`define TPC_AB_MAX      5'h14
`define TPC_C_EOT       7'h04
`define TPC_C_ENQ       7'h05
`define TPC_C_LF        7'h0a
`define TPC_C_CR        7'h0d
`define TPC_C_DC1       7'h11
`define TPC_C_DC2       7'h12
`define TPC_C_DC3       7'h13
`define TPC_C_DC4       7'h14
`define TPC_C_SP        7'h20
`define TPC_C_DEL       7'h7f
`define TPC_OFF_CTRL    12'h000
`define TPC_OFF_STAT    12'h004
`define TPC_OFF_ABLEN   12'h008
`define TPC_OFF_AB      12'h040
`define TPC_OFF_AB_END  12'h08c
`define TPC_CTRL_PAR    1:0
`define TPC_CTRL_RDRA   2
`define TPC_CTRL_ARF    3
`define TPC_CTRL_DBL    4
`define TPC_CTRL_PAUTO  5
`define TPC_CTRL_RDRM   6
`define TPC_CTRL_RST    7'h0c
`endif

// ==== verilog/tpc_pkg.sv ====
// Types for the teleprinter character controller.
package tpc_pkg;
  typedef enum logic [1:0] {
    TPC_PAR_EVEN  = 2'h0,
    TPC_PAR_MARK  = 2'h1,
    TPC_PAR_SPACE = 2'h2
  } tpc_par_t;
  typedef enum logic [2:0] {
    TPC_TX_IDLE  = 3'h1,
    TPC_TX_SHIFT = 3'h2,
    TPC_TX_BREAK = 3'h4
  } tpc_tx_t;
  typedef enum logic [2:0] {
    TPC_RX_IDLE = 3'h1,
    TPC_RX_BITS = 3'h2,
    TPC_RX_STOP = 3'h4
  } tpc_rx_t;
endpackage

// ==== verilog/tpc_char_ctrl.sv ====
// Teleprinter character controller: line framing, printer functions, answer-back, AHB-Lite registers.
`timescale 1ns/1ps
`include "tpc_params.svh"
module tpc_char_ctrl #(
  parameter int UNIT_CYC = `TPC_UNIT_CYC
) (
  input  wire logic        hclk,          // Bus clock
  input  wire logic        hresetn,       // Async reset, active low
  input  wire logic        hsel,          // Slave select
  input  wire logic [31:0] haddr,         // Address
  input  wire logic [1:0]  htrans,        // Transfer type
  input  wire logic        hwrite,        // Write
  input  wire logic [2:0]  hsize,         // Size, word only
  input  wire logic [31:0] hwdata,        // Write data
  input  wire logic        hready,        // Bus ready
  output logic      [31:0] hrdata,        // Read data
  output logic             hreadyout,     // Slave ready
  output logic             hresp,         // Response, always OKAY
  input  wire logic        line_rx,       // Receive line, high is marking
  input  wire logic        key_down,      // A keyboard key is held
  input  wire logic [6:0]  key_code,      // Keyboard code
  input  wire logic        repeat_key,    // Repeat key held
  input  wire logic        break_key,     // Break key held
  input  wire logic        eot_key,       // End-of-transmission key
  input  wire logic        ab_key,        // Local answer-back key
  input  wire logic        rdr_feed,      // Reader has a new code
  input  wire logic [7:0]  rdr_holes,     // Reader hole contacts
  input  wire logic        punch_on_key,  // Manual punch on
  input  wire logic        punch_off_key, // Manual punch off
  input  wire logic        paper_out,     // Paper supply exhausted
  input  wire logic        data_set,      // Data set attached
  output logic             line_tx,       // Send line, high is marking
  output logic             print_strobe,  // Print one character
  output logic      [6:0]  print_code,    // Character to print
  output logic             carriage_ret,  // Return to left margin
  output logic             paper_feed,    // Feed paper
  output logic      [1:0]  feed_lines,    // Lines to feed
  output logic             line_end_bell, // End-of-line bell pulse
  output logic             reader_run,    // Tape reader running
  output logic             punch_on,      // Tape punch on
  output logic             paper_alarm,   // Paper-out alarm
  output logic             call_refuse,   // Refuse incoming calls
  output logic             eot_sent       // End-of-transmission sent
);
  localparam logic [23:0] UNIT_M1 = 24'(UNIT_CYC - 1);
  localparam logic [23:0] HALF    = 24'(UNIT_CYC / 2);

  function automatic logic [7:0] kb_char(input logic [6:0] c, input logic [1:0] m);
    logic b8;
    b8 = 1'b1;
    if (m == tpc_pkg::TPC_PAR_EVEN)
      b8 = ^c;
    else if (m == tpc_pkg::TPC_PAR_SPACE)
      b8 = 1'b0;
    return {b8, c};
  endfunction

  function automatic logic is_print(input logic [6:0] c);
    return (c > `TPC_C_SP) && (c != `TPC_C_DEL);
  endfunction

  // Input synchronisers; s3 only feeds edge detection.
  logic [25:0] s1, s2, s3;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s1 <= 26'h2000000;
      s2 <= 26'h2000000;
      s3 <= 26'h2000000;
    end else begin
      s1 <= {line_rx, key_down, key_code, repeat_key, break_key, eot_key, ab_key,
             rdr_feed, rdr_holes, punch_on_key, punch_off_key, paper_out, data_set};
      s2 <= s1;
      s3 <= s2;
    end
  end
  logic       rx_s, rep_s, brk_s, po_s, ds_s, kd_s;
  logic [6:0] kc_s;
  logic [7:0] rh_s;
  logic       kd_r, eot_r, abk_r, rf_r, pon_r, poff_r;
  assign rx_s   = s2[25];
  assign kd_s   = s2[24];
  assign kc_s   = s2[23:17];
  assign rep_s  = s2[16];
  assign brk_s  = s2[15];
  assign rh_s   = s2[11:4];
  assign po_s   = s2[1];
  assign ds_s   = s2[0];
  assign kd_r   = s2[24] & ~s3[24];
  assign eot_r  = s2[14] & ~s3[14];
  assign abk_r  = s2[13] & ~s3[13];
  assign rf_r   = s2[12] & ~s3[12];
  assign pon_r  = s2[3] & ~s3[3];
  assign poff_r = s2[2] & ~s3[2];

  // Register file over AHB-Lite, zero wait states.
  logic [6:0]  ctrl_reg;
  logic [4:0]  ab_len_reg;
  logic [7:0]  ab_mem [`TPC_AB_MAX];
  logic        wr_pend;
  logic [11:0] wr_addr;
  logic [6:0]  pos_reg;
  logic [7:0]  rx_data;
  logic        ab_busy, kb_pend, eot_pend, rdr_pend;
  tpc_pkg::tpc_tx_t tx_st;
  tpc_pkg::tpc_rx_t rx_st;
  logic        a_phase;
  logic [11:0] a_off;
  logic [4:0]  a_idx;
  assign a_phase = hsel & htrans[1] & hready;
  assign a_off   = haddr[11:0];
  assign a_idx   = 5'(haddr[11:2] - 10'h010);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
      wr_pend   <= 1'b0;
      wr_addr   <= 12'h000;
      hrdata    <= 32'h00000000;
    end else begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
      wr_pend   <= a_phase & hwrite;
      wr_addr   <= a_off;
      hrdata    <= 32'h00000000;
      if (a_phase && !hwrite) begin
        if (a_off == `TPC_OFF_CTRL)
          hrdata <= {25'h0, ctrl_reg};
        else if (a_off == `TPC_OFF_STAT)
          hrdata <= {8'h0, rx_data, 3'h0, ab_busy, (tx_st != tpc_pkg::TPC_TX_IDLE),
                     paper_alarm, punch_on, reader_run, 1'b0, pos_reg};
        else if (a_off == `TPC_OFF_ABLEN)
          hrdata <= {27'h0, ab_len_reg};
        else if (a_off >= `TPC_OFF_AB && a_off <= `TPC_OFF_AB_END && a_off[1:0] == 2'h0)
          hrdata <= {24'h0, ab_mem[a_idx]};
      end
    end
  end

  logic [4:0] w_idx;
  assign w_idx = 5'(wr_addr[11:2] - 10'h010);
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_reg   <= `TPC_CTRL_RST;
      ab_len_reg <= 5'h00;
      for (int i = 0; i < `TPC_AB_MAX; i++)
        ab_mem[i] <= 8'h00;
    end else if (wr_pend) begin
      if (wr_addr == `TPC_OFF_CTRL)
        ctrl_reg <= hwdata[6:0];
      else if (wr_addr == `TPC_OFF_ABLEN)
        ab_len_reg <= (hwdata[4:0] > `TPC_AB_MAX) ? `TPC_AB_MAX : hwdata[4:0];
      else if (wr_addr >= `TPC_OFF_AB && wr_addr <= `TPC_OFF_AB_END && wr_addr[1:0] == 2'h0)
        ab_mem[w_idx] <= hwdata[7:0];
    end
  end

  // Receiver: start-stop framing, middle-of-unit sampling.
  logic [23:0] rx_cnt;
  logic [3:0]  rx_bits;
  logic [7:0]  rx_sr;
  logic        rx_valid;
  logic [6:0]  rc;
  assign rc = rx_data[6:0];
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rx_st    <= tpc_pkg::TPC_RX_IDLE;
      rx_cnt   <= 24'h000000;
      rx_bits  <= 4'h0;
      rx_sr    <= 8'h00;
      rx_valid <= 1'b0;
      rx_data  <= 8'h00;
    end else begin
      rx_valid <= 1'b0;
      rx_cnt   <= rx_cnt + 24'h000001;
      unique case (rx_st)
        tpc_pkg::TPC_RX_IDLE: begin
          rx_bits <= 4'h0;
          rx_cnt  <= UNIT_M1 - HALF;
          if (!rx_s)
            rx_st <= tpc_pkg::TPC_RX_BITS;
        end
        tpc_pkg::TPC_RX_BITS: begin
          if (rx_cnt == UNIT_M1) begin
            rx_cnt <= 24'h000000;
            if (rx_bits == 4'h0 && rx_s)
              rx_st <= tpc_pkg::TPC_RX_IDLE;
            else begin
              if (rx_bits != 4'h0)
                rx_sr <= {rx_s, rx_sr[7:1]};
              rx_bits <= rx_bits + 4'h1;
              if (rx_bits == `TPC_INFO_BITS)
                rx_st <= tpc_pkg::TPC_RX_STOP;
            end
          end
        end
        tpc_pkg::TPC_RX_STOP: begin
          if (rx_cnt == UNIT_M1) begin
            rx_st <= tpc_pkg::TPC_RX_IDLE;
            if (rx_s) begin
              rx_valid <= 1'b1;
              rx_data  <= rx_sr;
            end
          end
        end
      endcase
    end
  end

  // Printer: position counter and function decoding.
  logic       adv, do_arf;
  assign adv    = rx_valid && (is_print(rc) || rc == `TPC_C_SP) && pos_reg < `TPC_LINE_LEN;
  assign do_arf = adv && ctrl_reg[`TPC_CTRL_ARF] && (pos_reg + 7'h01 == `TPC_LINE_LEN);
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pos_reg       <= 7'h00;
      print_strobe  <= 1'b0;
      print_code    <= 7'h00;
      carriage_ret  <= 1'b0;
      paper_feed    <= 1'b0;
      feed_lines    <= 2'h0;
      line_end_bell <= 1'b0;
    end else begin
      print_strobe  <= 1'b0;
      carriage_ret  <= 1'b0;
      paper_feed    <= 1'b0;
      line_end_bell <= 1'b0;
      if (rx_valid && is_print(rc)) begin
        print_strobe <= 1'b1;
        print_code   <= rc;
      end
      if (adv) begin
        pos_reg <= pos_reg + 7'h01;
        if (pos_reg + 7'h01 == `TPC_BELL_POS)
          line_end_bell <= 1'b1;
      end
      if (do_arf) begin
        pos_reg      <= 7'h00;
        carriage_ret <= 1'b1;
        paper_feed   <= 1'b1;
        feed_lines   <= 2'h1;
      end else if (rx_valid && rc == `TPC_C_CR) begin
        pos_reg      <= 7'h00;
        carriage_ret <= 1'b1;
      end else if (rx_valid && rc == `TPC_C_LF) begin
        paper_feed <= 1'b1;
        feed_lines <= ctrl_reg[`TPC_CTRL_DBL] ? 2'h2 : 2'h1;
      end
    end
  end

  // Reader, punch and paper-out control.
  logic rdr_auto_run;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rdr_auto_run <= 1'b0;
      reader_run   <= 1'b0;
      punch_on     <= 1'b0;
      paper_alarm  <= 1'b0;
      call_refuse  <= 1'b0;
    end else begin
      if (rx_valid && ctrl_reg[`TPC_CTRL_RDRA] && rc == `TPC_C_DC1)
        rdr_auto_run <= 1'b1;
      else if (rx_valid && ctrl_reg[`TPC_CTRL_RDRA] && rc == `TPC_C_DC3)
        rdr_auto_run <= 1'b0;
      reader_run <= (rdr_auto_run & ctrl_reg[`TPC_CTRL_RDRA]) | ctrl_reg[`TPC_CTRL_RDRM];
      // Manual keys are checked first so they win over codes from the line.
      if (pon_r)
        punch_on <= 1'b1;
      else if (poff_r)
        punch_on <= 1'b0;
      else if (rx_valid && ctrl_reg[`TPC_CTRL_PAUTO] && rc == `TPC_C_DC2)
        punch_on <= 1'b1;
      else if (rx_valid && ctrl_reg[`TPC_CTRL_PAUTO] && rc == `TPC_C_DC4)
        punch_on <= 1'b0;
      paper_alarm <= po_s & ds_s;
      call_refuse <= po_s & ds_s;
    end
  end

  // Transmit source selection; answer-back has priority over everything except break.
  logic [4:0] ab_idx;
  logic [7:0] rdr_code;
  logic       launch;
  logic [7:0] lcode;
  logic [1:0] lsrc;
  always_comb begin
    launch = 1'b0;
    lcode  = 8'h00;
    lsrc   = 2'h0;
    if (tx_st == tpc_pkg::TPC_TX_IDLE && !brk_s) begin
      if (ab_busy) begin
        launch = 1'b1;
        lcode  = ab_mem[ab_idx];
      end else if (eot_pend) begin
        launch = 1'b1;
        lcode  = kb_char(`TPC_C_EOT, ctrl_reg[`TPC_CTRL_PAR]);
        lsrc   = 2'h1;
      end else if (kb_pend || (rep_s && kd_s)) begin
        launch = 1'b1;
        lcode  = kb_char(kc_s, ctrl_reg[`TPC_CTRL_PAR]);
        lsrc   = 2'h2;
      end else if (rdr_pend && reader_run) begin
        launch = 1'b1;
        lcode  = rdr_code;
        lsrc   = 2'h3;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ab_busy  <= 1'b0;
      ab_idx   <= 5'h00;
      kb_pend  <= 1'b0;
      eot_pend <= 1'b0;
      rdr_pend <= 1'b0;
      rdr_code <= 8'h00;
      eot_sent <= 1'b0;
    end else begin
      eot_sent <= launch && lsrc == 2'h1;
      if (!ab_busy && (abk_r || (rx_valid && rc == `TPC_C_ENQ))) begin
        ab_busy <= ab_len_reg != 5'h00;
        ab_idx  <= 5'h00;
      end else if (launch && lsrc == 2'h0) begin
        if (ab_idx == ab_len_reg - 5'h01)
          ab_busy <= 1'b0;
        ab_idx <= ab_idx + 5'h01;
      end
      // A new event in the launch cycle keeps its flag set.
      if (kd_r)
        kb_pend <= 1'b1;
      else if (launch && lsrc == 2'h2)
        kb_pend <= 1'b0;
      if (eot_r)
        eot_pend <= 1'b1;
      else if (launch && lsrc == 2'h1)
        eot_pend <= 1'b0;
      if (rf_r && reader_run) begin
        rdr_pend <= 1'b1;
        rdr_code <= rh_s;
      end else if (launch && lsrc == 2'h3)
        rdr_pend <= 1'b0;
    end
  end

  // Transmitter: eleven-unit frame, lowest bit first.
  logic [23:0] tx_cnt;
  logic [3:0]  tx_bits;
  logic [9:0]  tx_sr;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tx_st   <= tpc_pkg::TPC_TX_IDLE;
      tx_cnt  <= 24'h000000;
      tx_bits <= 4'h0;
      tx_sr   <= 10'h3ff;
      line_tx <= 1'b1;
    end else begin
      tx_cnt <= tx_cnt + 24'h000001;
      unique case (tx_st)
        tpc_pkg::TPC_TX_IDLE: begin
          tx_cnt  <= 24'h000000;
          tx_bits <= 4'h0;
          line_tx <= 1'b1;
          if (brk_s) begin
            tx_st   <= tpc_pkg::TPC_TX_BREAK;
            line_tx <= 1'b0;
          end else if (launch) begin
            tx_st   <= tpc_pkg::TPC_TX_SHIFT;
            tx_sr   <= {2'h3, lcode};
            line_tx <= 1'b0;
          end
        end
        tpc_pkg::TPC_TX_SHIFT: begin
          if (brk_s) begin
            tx_st   <= tpc_pkg::TPC_TX_BREAK;
            line_tx <= 1'b0;
          end else if (tx_cnt == UNIT_M1) begin
            tx_cnt <= 24'h000000;
            if (tx_bits == `TPC_FRAME_LAST) begin
              tx_st   <= tpc_pkg::TPC_TX_IDLE;
              line_tx <= 1'b1;
            end else begin
              line_tx <= tx_sr[0];
              tx_sr   <= {1'b1, tx_sr[9:1]};
              tx_bits <= tx_bits + 4'h1;
            end
          end
        end
        tpc_pkg::TPC_TX_BREAK: begin
          line_tx <= 1'b0;
          if (!brk_s) begin
            tx_st   <= tpc_pkg::TPC_TX_IDLE;
            line_tx <= 1'b1;
          end
        end
      endcase
    end
  end

  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  AST_PAR_EVEN: assert property (launch && lsrc[1] != lsrc[0] && ctrl_reg[1:0] == 2'h0 |=> !(^tx_sr[7:0]))
    else $error("Even parity character has odd mark count.");
  AST_PAR_FIXED: assert property (launch && lsrc[1] != lsrc[0] && ctrl_reg[1:0] == 2'h2 |=> !tx_sr[7])
    else $error("Forced spacing eighth bit is marking.");
  AST_START_UNIT: assert property ($rose(tx_st == tpc_pkg::TPC_TX_SHIFT) |-> !line_tx ##1 !line_tx)
    else $error("Frame did not open with a spacing start unit.");
  AST_BREAK_OPEN: assert property (brk_s ##1 brk_s |-> !line_tx)
    else $error("Line not open during break.");
  AST_FRAME_UNITS: assert property (tx_st == tpc_pkg::TPC_TX_SHIFT |-> tx_bits <= `TPC_FRAME_LAST)
    else $error("Frame longer than eleven units.");
  AST_CR_MARGIN: assert property (rx_valid && rc == `TPC_C_CR |=> pos_reg == 7'h00 && carriage_ret)
    else $error("Carriage return left position off margin.");
  AST_POS_MAX: assert property (pos_reg <= `TPC_LINE_LEN)
    else $error("Print position beyond line end.");
  AST_BELL_POS: assert property (line_end_bell |-> pos_reg == `TPC_BELL_POS)
    else $error("Bell rang away from its position.");
  AST_NO_PRINT_FN: assert property (print_strobe |-> is_print(print_code))
    else $error("Function code was printed.");
  AST_READER_DC1: assert property (rx_valid && rc == `TPC_C_DC1 && ctrl_reg[2] |=> ##1 reader_run)
    else $error("Reader did not start on DC1.");
  AST_PAPER_OUT: assert property (po_s && ds_s |=> paper_alarm && call_refuse)
    else $error("Paper out did not refuse calls.");
  AST_ARF_FEED: assert property (do_arf |=> pos_reg == 7'h00 && paper_feed && feed_lines == 2'h1)
    else $error("Auto return did not feed one line.");

  COV_ARF: cover property (do_arf);
  COV_BREAK: cover property (tx_st == tpc_pkg::TPC_TX_BREAK);
  COV_AB: cover property (ab_busy && launch);
  COV_RX: cover property (rx_valid && is_print(rc));
endmodule // tpc_char_ctrl

// ==== verif/tpc_far_station.sv ====
// Distant station model: frames characters onto the receive line and decodes the send line.
`timescale 1ns/1ps
module tpc_far_station #(
  parameter int UNIT = 16
) (
  input  wire logic hclk,    // Clock
  input  wire logic line_tx, // Device send line
  output logic      line_rx  // Device receive line
);
  logic [7:0] rx_byte;
  logic [7:0] b;
  logic       s1;
  int         n_rx;
  int         n_err;
  initial begin
    line_rx = 1'b1;
    rx_byte = 8'h00;
    n_rx = 0;
    n_err = 0;
  end
  task automatic frame(input logic [7:0] d);
    logic [10:0] f;
    f = {2'b11, d, 1'b0};
    for (int i = 0; i < 11; i++) begin
      @(posedge hclk);
      line_rx <= f[i];
      repeat (UNIT - 1) @(posedge hclk);
    end
  endtask
  // Codes below 1C hex are padded with two DEL frames so that a slow printer mechanism has time to finish.
  task automatic send(input logic [7:0] d);
    frame(d);
    if (d[6:0] < 7'h1c) begin
      frame(8'h7f);
      frame(8'h7f);
    end
  endtask
  always begin
    @(negedge line_tx);
    repeat (UNIT / 2) @(posedge hclk);
    if (line_tx !== 1'b0) n_err++;
    for (int i = 0; i < 8; i++) begin
      repeat (UNIT) @(posedge hclk);
      b[i] = line_tx;
    end
    repeat (UNIT) @(posedge hclk);
    s1 = line_tx;
    repeat (UNIT) @(posedge hclk);
    if (s1 !== 1'b1 || line_tx !== 1'b1) n_err++;
    rx_byte = b;
    n_rx++;
  end
endmodule // tpc_far_station

// ==== verif/tpc_char_ctrl_tb.sv ====
// Self-checking bench for the teleprinter character controller.
`timescale 1ns/1ps
`include "tpc_params.svh"
module tpc_char_ctrl_tb;
  logic        hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, r;
  logic [1:0]  htrans = 2'h0, feed_lines, last_feed;
  logic [2:0]  hsize = 3'h2;
  logic        hreadyout, hresp, line_rx, line_tx, key_down = 1'b0, repeat_key = 1'b0;
  logic        break_key = 1'b0, eot_key = 1'b0, ab_key = 1'b0, rdr_feed = 1'b0;
  logic        punch_on_key = 1'b0, punch_off_key = 1'b0, paper_out = 1'b0, data_set = 1'b0;
  logic        print_strobe, carriage_ret, paper_feed, line_end_bell, reader_run;
  logic        punch_on, paper_alarm, call_refuse, eot_sent;
  logic [6:0]  key_code = 7'h00, print_code, last_print;
  logic [7:0]  rdr_holes = 8'h00;
  int          num_errors = 0, checked = 0, n_pr = 0, n_cr = 0, n_fd = 0, n_bell = 0, n_eot = 0;
  always #12.5 hclk = ~hclk;
  tpc_char_ctrl #(.UNIT_CYC(16)) u_dut (
    .hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready(hreadyout),
    .hrdata, .hreadyout, .hresp, .line_rx, .key_down, .key_code, .repeat_key, .break_key,
    .eot_key, .ab_key, .rdr_feed, .rdr_holes, .punch_on_key, .punch_off_key, .paper_out,
    .data_set, .line_tx, .print_strobe, .print_code, .carriage_ret, .paper_feed, .feed_lines,
    .line_end_bell, .reader_run, .punch_on, .paper_alarm, .call_refuse, .eot_sent
  );
  tpc_far_station #(.UNIT(16)) u_far (.hclk(hclk), .line_tx(line_tx), .line_rx(line_rx));
  always @(posedge hclk) begin
    if (print_strobe === 1'b1) begin
      n_pr++;
      last_print = print_code;
    end
    if (paper_feed === 1'b1) begin
      n_fd++;
      last_feed = feed_lines;
    end
    if (carriage_ret === 1'b1) n_cr++;
    if (line_end_bell === 1'b1) n_bell++;
    if (eot_sent === 1'b1) n_eot++;
  end
  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic summarize();
    $display("checks %0d mismatches %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  task automatic tmo(input int k);
    if (k >= 400) begin
      num_errors++;
      summarize();
    end
  endtask
  task automatic hwait();
    int k;
    k = 0;
    do begin
      @(posedge hclk);
      k++;
    end while (hreadyout !== 1'b1 && k < 400);
    tmo(k);
  endtask
  task automatic ahb(input logic [11:0] a, input logic w, input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {20'h0, a};
    hwrite <= w;
    hwait();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    hwait();
    r = hrdata;
  endtask
  task automatic wait_rx(input int n0);
    int k;
    k = 0;
    while (u_far.n_rx == n0 && k < 400) begin
      @(posedge hclk);
      k++;
    end
    tmo(k);
  endtask
  task automatic key(input logic [6:0] c, input logic [7:0] exp);
    int n0;
    n0 = u_far.n_rx;
    key_code <= c;
    key_down <= 1'b1;
    wait_rx(n0);
    key_down <= 1'b0;
    repeat (4) @(posedge hclk);
    check("tx_byte", u_far.rx_byte, exp);
  endtask
  task automatic rx(input logic [7:0] b);
    u_far.send(b);
    repeat (8) @(posedge hclk);
  endtask
  task automatic pos(input logic [6:0] exp);
    ahb(`TPC_OFF_STAT, 1'b0, 32'h0);
    check("position", r[6:0], exp);
    check("hresp", hresp, 32'h0);
  endtask
  initial begin
    #2500000;
    num_errors++;
    summarize();
  end
  initial begin
    int n0;
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    ahb(`TPC_OFF_CTRL, 1'b0, 32'h0);
    check("ctrl_reset", r, 32'h0c);
    ahb(12'h010, 1'b1, 32'hff);
    ahb(12'h010, 1'b0, 32'h0);
    check("unmapped", r, 32'h0);
    for (int m = 0; m < 4; m++) begin
      ahb(`TPC_OFF_CTRL, 1'b1, 32'h0c | m);
      key(7'h41, {m[0], 7'h41});
      key(7'h43, {m != 2, 7'h43});
    end
    n0 = u_far.n_rx;
    eot_key <= 1'b1;
    wait_rx(n0);
    eot_key <= 1'b0;
    check("eot_byte", u_far.rx_byte, 8'h84);
    check("eot_pulse", n_eot, 32'h1);
    $display("send tests done");
    ahb(`TPC_OFF_CTRL, 1'b1, 32'h0c);
    rx(8'h41);
    check("print_code", last_print, 7'h41);
    rx(8'h20);
    rx(8'h00);
    check("prints", n_pr, 32'h1);
    pos(7'h02);
    rx(8'h0d);
    check("returns", n_cr, 32'h1);
    pos(7'h00);
    ahb(`TPC_OFF_CTRL, 1'b1, 32'h1c);
    rx(8'h0a);
    check("feed_lines", last_feed, 2'h2);
    ahb(`TPC_OFF_CTRL, 1'b1, 32'h0c);
    for (int i = 1; i <= 72; i++) begin
      rx(8'h41);
      if (i >= 70) check("bell", n_bell, i > 70);
    end
    check("auto_return", n_cr, 32'h2);
    check("auto_feed", n_fd, 32'h2);
    check("auto_lines", last_feed, 32'h1);
    pos(7'h00);
    ahb(`TPC_OFF_CTRL, 1'b1, 32'h04);
    for (int i = 0; i < 73; i++) rx(8'h41);
    pos(7'h48);
    $display("print tests done");
    ahb(`TPC_OFF_CTRL, 1'b1, 32'h2c);
    rx(8'h11);
    check("reader_on", reader_run, 1'b1);
    rx(8'h13);
    check("reader_off", reader_run, 1'b0);
    rx(8'h12);
    check("punch_auto", punch_on, 1'b1);
    punch_off_key <= 1'b1;
    repeat (8) @(posedge hclk);
    check("punch_manual", punch_on, 1'b0);
    punch_off_key <= 1'b0;
    punch_on_key <= 1'b1;
    repeat (8) @(posedge hclk);
    check("punch_manual", punch_on, 1'b1);
    punch_on_key <= 1'b0;
    rx(8'h14);
    check("punch_auto", punch_on, 1'b0);
    paper_out <= 1'b1;
    data_set <= 1'b1;
    repeat (8) @(posedge hclk);
    check("paper_set", {paper_alarm, call_refuse}, 2'h3);
    data_set <= 1'b0;
    repeat (8) @(posedge hclk);
    check("paper_noset", {paper_alarm, call_refuse}, 2'h0);
    ahb(`TPC_OFF_ABLEN, 1'b1, 32'h1f);
    ahb(`TPC_OFF_ABLEN, 1'b0, 32'h0);
    check("ab_len", r, 32'h14);
    ahb(`TPC_OFF_ABLEN, 1'b1, 32'h2);
    ahb(`TPC_OFF_AB, 1'b1, 32'hc8);
    ahb(`TPC_OFF_AB + 12'h004, 1'b1, 32'h49);
    n0 = u_far.n_rx;
    ab_key <= 1'b1;
    wait_rx(n0);
    ab_key <= 1'b0;
    check("ab_local", u_far.rx_byte, 8'hc8);
    wait_rx(n0 + 1);
    check("ab_local", u_far.rx_byte, 8'h49);
    n0 = u_far.n_rx;
    rx(8'h05);
    check("ab_remote", u_far.n_rx - n0, 32'h2);
    check("ab_remote", u_far.rx_byte, 8'h49);
    n0 = u_far.n_rx;
    key_code <= 7'h55;
    repeat_key <= 1'b1;
    key_down <= 1'b1;
    wait_rx(n0);
    wait_rx(n0 + 1);
    key_down <= 1'b0;
    repeat_key <= 1'b0;
    repeat (200) @(posedge hclk);
    check("repeat", u_far.n_rx - n0, 32'h2);
    check("repeat", u_far.rx_byte, 8'h55);
    ahb(`TPC_OFF_CTRL, 1'b1, 32'h6c);
    ahb(`TPC_OFF_CTRL, 1'b0, 32'h0);
    check("ctrl_rw", r, 32'h6c);
    n0 = u_far.n_rx;
    rdr_holes <= 8'ha5;
    rdr_feed <= 1'b1;
    wait_rx(n0);
    rdr_feed <= 1'b0;
    check("reader_code", u_far.rx_byte, 8'ha5);
    $display("answer-back, repeat and reader tests done");
    check("frame_faults", u_far.n_err, 32'h0);
    break_key <= 1'b1;
    repeat (6) @(posedge hclk);
    check("break", line_tx, 1'b0);
    repeat (60) @(posedge hclk);
    check("break_held", line_tx, 1'b0);
    break_key <= 1'b0;
    repeat (8) @(posedge hclk);
    check("idle", line_tx, 1'b1);
    $display("control tests done");
    summarize();
  end
endmodule // tpc_char_ctrl_tb
